// File: hw/bcc_top.sv
// Bridge command word control bits with AXI4-Lite register access
`timescale 1ns/10ps
// Function
// - Interrupt disable bit reads zero; bridge interrupts go out on irq from enabled sticky event status.
// - Fast back-to-back, wait, palette snoop, special cycle bits hardwired zero.
// - Error reporting enable or the matching device-control enable (bit 1 non-fatal, bit 2 fatal) allows own non-fatal and fatal error reports.
// - With enable set, detected PCI-side error pin sends error messages upstream.
// - Own-error report allowed by command bit OR device-control reporting enables; pin reports need the command bit.
// - Poisoned received TLP sets parity flag only when parity response enabled.
// - Poisoning an outgoing write also sets the flag when parity response enabled.
// - Write-invalidate enable promotes memory writes; off means no promotion.
module bcc_top (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire bcc_pkg::bcc_err_t own_err,
  input  wire logic              pci_err_pin_n,
  input  wire logic              pci_err_fatal,
  input  wire logic              rx_poisoned,
  input  wire logic              tx_poisoned_write,
  input  wire logic              mem_write_req,
  output bcc_pkg::bcc_ctrl_t     ctrl,
  output bcc_pkg::bcc_err_t      err_msg,
  output logic                   promote_write_inval,
  output logic                   irq
);
  import bcc_pkg::*;

  logic [31:0]     cmd_word;
  logic            mpe_flag;
  logic [2:0]      devctl;
  logic [EV_W-1:0] irq_en;
  logic [EV_W-1:0] irq_clr;
  logic [EV_W-1:0] irq_st;
  logic [EV_W-1:0] events;
  logic            aw_held;
  logic            w_held;
  logic [7:0]      aw_addr;
  logic [31:0]     w_data;
  logic [3:0]      w_strb;
  logic            do_write;
  logic            pci_err_seen;
  logic            pci_err_prev;
  logic            pci_err_rise;
  logic            report_ok;
  logic            mpe_set;
  logic [31:0]     next_rdata;
  logic [1:0]      next_rresp;

  // Write channel capture, either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr)
        ADDR_CMD, ADDR_FLAGS, ADDR_IRQ_EN, ADDR_IRQ_CLR, ADDR_DEVCTL: s_axi_bresp <= RESP_OKAY;
        ADDR_IRQ_ST: s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only writable bits stored; fixed-zero bits never load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_word <= CMD_RESET;
    end else if (do_write && aw_addr == ADDR_CMD) begin
      if (w_strb[0]) begin
        cmd_word[7:0] <= w_data[7:0] & CMD_WMASK[7:0];
      end
      if (w_strb[1]) begin
        cmd_word[15:8] <= w_data[15:8] & CMD_WMASK[15:8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      devctl <= 3'h0;
    end else if (do_write && aw_addr == ADDR_DEVCTL && w_strb[0]) begin
      devctl <= w_data[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en <= '0;
    end else if (do_write && aw_addr == ADDR_IRQ_EN && w_strb[0]) begin
      irq_en <= w_data[EV_W-1:0];
    end
  end

  assign irq_clr = (do_write && aw_addr == ADDR_IRQ_CLR && w_strb[0]) ? w_data[EV_W-1:0] : '0;

  assign ctrl.error_report_enable     = cmd_word[BIT_ERR_REPORT];
  assign ctrl.parity_response_enable  = cmd_word[BIT_PARITY_RESP];
  assign ctrl.write_invalidate_enable = cmd_word[BIT_WR_INVAL];
  assign ctrl.bus_master_enable       = cmd_word[BIT_BUS_MASTER];

  // Master parity error flag, set wins over write-one clear
  assign mpe_set = ctrl.parity_response_enable && (rx_poisoned || tx_poisoned_write);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mpe_flag <= 1'b0;
    end else if (mpe_set) begin
      mpe_flag <= 1'b1;
    end else if (do_write && aw_addr == ADDR_FLAGS && w_strb[3] && w_data[BIT_MPE_FLAG]) begin
      mpe_flag <= 1'b0;
    end
  end

  // PCI-side error pin, active low, edge detected after sync
  bcc_sync u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (!pci_err_pin_n),
    .level   (pci_err_seen)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pci_err_prev <= 1'b0;
    end else begin
      pci_err_prev <= pci_err_seen;
    end
  end

  assign pci_err_rise = pci_err_seen && !pci_err_prev;
  assign report_ok    = ctrl.error_report_enable;

  // Error message pulses, one cycle each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_msg <= '0;
    end else begin
      err_msg.nonfatal <= (own_err.nonfatal && (report_ok || devctl[BIT_DC_NONFATAL]))
                          || (pci_err_rise && !pci_err_fatal && report_ok);
      err_msg.fatal    <= (own_err.fatal && (report_ok || devctl[BIT_DC_FATAL]))
                          || (pci_err_rise && pci_err_fatal && report_ok);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      promote_write_inval <= 1'b0;
    end else begin
      promote_write_inval <= mem_write_req && ctrl.write_invalidate_enable;
    end
  end

  assign events[EV_MPE]     = mpe_set;
  assign events[EV_ERRMSG]  = |err_msg;
  assign events[EV_PCI_ERR] = pci_err_rise;

  bcc_irq #(.W(EV_W)) u_irq (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .event_in (events),
    .clear    (irq_clr),
    .enable   (irq_en),
    .status   (irq_st),
    .irq      (irq)
  );

  // Read channel
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = RESP_OKAY;
    case (s_axi_araddr)
      ADDR_CMD:     next_rdata = cmd_word;
      ADDR_FLAGS:   next_rdata[BIT_MPE_FLAG] = mpe_flag;
      ADDR_IRQ_ST:  next_rdata[EV_W-1:0] = irq_st;
      ADDR_IRQ_EN:  next_rdata[EV_W-1:0] = irq_en;
      ADDR_IRQ_CLR: next_rdata = 32'h0000_0000;
      ADDR_DEVCTL:  next_rdata[2:0] = devctl;
      default:      next_rresp = RESP_SLVERR;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  chk_fixed_zero_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_word[BIT_IRQ_OFF] == 1'b0 && cmd_word[BIT_FAST_B2B] == 1'b0 && cmd_word[BIT_WAIT_CTRL] == 1'b0
    && cmd_word[BIT_PALETTE] == 1'b0 && cmd_word[BIT_SPECIAL] == 1'b0)
    else $error("fixed zero command bit is set");

  chk_own_err_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    own_err.nonfatal && !cmd_word[BIT_ERR_REPORT] && !devctl[BIT_DC_NONFATAL] && !pci_err_rise
    |=> !err_msg.nonfatal)
    else $error("non-fatal report sent while disabled");

  chk_pin_report: assert property (@(posedge aclk) disable iff (!aresetn)
    pci_err_rise && cmd_word[BIT_ERR_REPORT] |=> (err_msg.fatal || err_msg.nonfatal))
    else $error("pci error pin not reported");

  chk_or_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    own_err.fatal && devctl[BIT_DC_FATAL] |=> err_msg.fatal)
    else $error("device control enable did not report fatal error");

  chk_mpe_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    !mpe_flag && !cmd_word[BIT_PARITY_RESP] |=> !mpe_flag)
    else $error("parity flag set while parity response off");

  chk_mpe_tx_set: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_poisoned_write && cmd_word[BIT_PARITY_RESP] |=> mpe_flag)
    else $error("poisoned write did not set parity flag");

  chk_promote_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    mem_write_req |=> promote_write_inval == $past(cmd_word[BIT_WR_INVAL]))
    else $error("write promotion does not follow enable");

  chk_ctrl_write: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_addr == ADDR_CMD && w_strb[0] |=> cmd_word[7:0] == ($past(w_data[7:0]) & CMD_WMASK[7:0]))
    else $error("control write not stored");

  chk_master_reported: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_addr == ADDR_CMD && w_strb[0]
    |=> ctrl.bus_master_enable == $past(w_data[BIT_BUS_MASTER]))
    else $error("bus master enable does not follow write");

  chk_fatal_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    own_err.fatal && !cmd_word[BIT_ERR_REPORT] && !devctl[BIT_DC_FATAL] && !pci_err_rise
    |=> !err_msg.fatal)
    else $error("fatal report sent while disabled");

  chk_mpe_rx_set: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_poisoned && cmd_word[BIT_PARITY_RESP] |=> mpe_flag)
    else $error("poisoned completion did not set parity flag");

  chk_promote_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !cmd_word[BIT_WR_INVAL] |=> !promote_write_inval)
    else $error("write promoted while enable is off");

  cov_pin_report: cover property (@(posedge aclk) disable iff (!aresetn) pci_err_rise && report_ok);
  cov_mpe_set: cover property (@(posedge aclk) disable iff (!aresetn) mpe_set ##1 mpe_flag);
  cov_promote: cover property (@(posedge aclk) disable iff (!aresetn) promote_write_inval);
  cov_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
  cov_own_fatal: cover property (@(posedge aclk) disable iff (!aresetn) own_err.fatal && report_ok);
endmodule : bcc_top

// File: hw/bcc_pkg.sv
// Package: offsets, field positions and types of the bridge command word block
package bcc_pkg;

  localparam logic [7:0] ADDR_CMD     = 8'h00;
  localparam logic [7:0] ADDR_FLAGS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
  localparam logic [7:0] ADDR_DEVCTL  = 8'h14;

  localparam int BIT_IRQ_OFF     = 10;
  localparam int BIT_FAST_B2B    = 9;
  localparam int BIT_ERR_REPORT  = 8;
  localparam int BIT_WAIT_CTRL   = 7;
  localparam int BIT_PARITY_RESP = 6;
  localparam int BIT_PALETTE     = 5;
  localparam int BIT_WR_INVAL    = 4;
  localparam int BIT_SPECIAL     = 3;
  localparam int BIT_BUS_MASTER  = 2;

  // Flag register layout: master parity error flag
  localparam int BIT_MPE_FLAG = 24;

  // Device-control reporting enables
  localparam int BIT_DC_NONFATAL = 1;
  localparam int BIT_DC_FATAL    = 2;

  // Interrupt event bits
  localparam int EV_MPE     = 0;
  localparam int EV_ERRMSG  = 1;
  localparam int EV_PCI_ERR = 2;
  localparam int EV_W       = 3;

  localparam logic [31:0] CMD_RESET    = 32'h0000_0000;
  localparam logic [31:0] CMD_WMASK    = 32'h0000_0154;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef struct packed {
    logic error_report_enable;
    logic parity_response_enable;
    logic write_invalidate_enable;
    logic bus_master_enable;
  } bcc_ctrl_t;

  typedef struct packed {
    logic fatal;
    logic nonfatal;
  } bcc_err_t;

endpackage : bcc_pkg

// File: hw/bcc_sync.sv
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/10ps
module bcc_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level
);
  import bcc_pkg::*;

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule : bcc_sync

// File: hw/bcc_irq.sv
// Sticky interrupt status with enable and write-one clear
`timescale 1ns/10ps
module bcc_irq #(
  parameter int W = 3
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] event_in,
  input  wire logic [W-1:0] clear,
  input  wire logic [W-1:0] enable,
  output logic      [W-1:0] status,
  output logic              irq
);
  import bcc_pkg::*;

  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          status[i] <= 1'b0;
        end else if (event_in[i]) begin
          status[i] <= 1'b1;
        end else if (clear[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(status & enable);
endmodule : bcc_irq

// File: dv/bcc_partner.sv
// Far-side model: PCI agent error pin and upstream message sink
`timescale 1ns/10ps
module bcc_partner (
  input  wire logic              aclk,
  input  wire logic              assert_req,
  input  wire bcc_pkg::bcc_err_t err_msg,
  output logic                   pin_n,
  output int                     n_fatal,
  output int                     n_nonfatal
);
  import bcc_pkg::*;
  int low_left = 0;
  initial begin
    pin_n = 1'b1;
    n_fatal = 0;
    n_nonfatal = 0;
  end
  // Agent pulls the error pin low for eight cycles; pull-up restores it
  always @(posedge aclk) begin
    if (assert_req)
      low_left = 8;
    else if (low_left > 0)
      low_left--;
    pin_n <= (low_left == 0);
  end
  // Upstream side tallies message requests
  always @(negedge aclk) begin
    n_fatal += err_msg.fatal;
    n_nonfatal += err_msg.nonfatal;
  end
endmodule : bcc_partner

// File: dv/bcc_top_bench.sv
// Self-checking bench for the bridge command word block
`timescale 1ns/10ps
module bcc_top_bench;
  import bcc_pkg::*;
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rnd = 32'h47da284b;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, pin_n, irq, prom;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb = 4'hf;
  logic        pin_req = 0, err_fatal = 0, rx_p = 0, tx_p = 0, mwr = 0, prom_seen = 0;
  bcc_err_t    own_err = '0, err_msg, msg_seen = '0;
  bcc_ctrl_t   ctrl;
  int          n_fatal, n_nonfatal, n_mismatch = 0, n_compared = 0, cyc = 0;
  logic [31:0] q_data[$];
  logic [1:0]  q_resp[$];
  logic [1:0]  q_bresp[$];

  always #2 aclk = ~aclk;

  bcc_top bcc_top_i (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .own_err,
    .pci_err_pin_n(pin_n), .pci_err_fatal(err_fatal), .rx_poisoned(rx_p),
    .tx_poisoned_write(tx_p), .mem_write_req(mwr), .ctrl, .err_msg,
    .promote_write_inval(prom), .irq);

  bcc_partner bcc_partner_i (.aclk, .assert_req(pin_req), .err_msg, .pin_n, .n_fatal, .n_nonfatal);

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // Handshakes judged at the falling edge, released after the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    q_bresp.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end while (!tb);
    bready <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    q_data.push_back(e);
    q_resp.push_back(er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      @(posedge aclk);
      if (ta) arvalid <= 0;
    end while (!tr);
    rready <= 0;
  endtask : rd

  // One-cycle event pulse {fatal, nonfatal, rx, tx, mwr, pin}, then settle
  task automatic ev(input logic [5:0] v);
    @(posedge aclk);
    msg_seen = '0;
    prom_seen = 0;
    {own_err, rx_p, tx_p, mwr, pin_req} <= v;
    @(posedge aclk);
    {own_err, rx_p, tx_p, mwr, pin_req} <= '0;
    repeat (16) @(posedge aclk);
  endtask : ev

  // Read and write responses taken off their queues as they appear
  always @(negedge aclk) begin
    msg_seen |= err_msg;
    prom_seen |= prom;
    if (bvalid && bready && q_bresp.size() > 0)
      cmp("bresp", q_bresp.pop_front(), bresp);
    if (rvalid && rready && q_data.size() > 0) begin
      cmp("rdata", q_data.pop_front(), rdata);
      cmp("rresp", q_resp.pop_front(), rresp);
    end
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    cmp("ctrl", 4'h0, ctrl);
    rd(ADDR_CMD, CMD_RESET, RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      wr(ADDR_CMD, rnd, RESP_OKAY);
      rd(ADDR_CMD, rnd & CMD_WMASK, RESP_OKAY);
    end
    wr(ADDR_CMD, 32'hffff_ffff, RESP_OKAY);
    rd(ADDR_CMD, 32'h0000_0154, RESP_OKAY);
    cmp("ctrl", 4'hf, ctrl);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'h1, RESP_SLVERR);
    wr(ADDR_CMD, 32'h0000_0004, RESP_OKAY);
    wr(ADDR_IRQ_EN, 32'h7, RESP_OKAY);
    ev(6'b001000);
    rd(ADDR_FLAGS, 32'h0, RESP_OKAY);
    wr(ADDR_CMD, 32'h0000_0044, RESP_OKAY);
    ev(6'b001000);
    rd(ADDR_FLAGS, 32'h0100_0000, RESP_OKAY);
    rd(ADDR_IRQ_ST, 32'h1, RESP_OKAY);
    cmp("irq", 1'b1, irq);
    wr(ADDR_FLAGS, 32'h0100_0000, RESP_OKAY);
    wr(ADDR_IRQ_CLR, 32'h7, RESP_OKAY);
    rd(ADDR_FLAGS, 32'h0, RESP_OKAY);
    rd(ADDR_IRQ_CLR, 32'h0, RESP_OKAY);
    cmp("irq", 1'b0, irq);
    wr(ADDR_IRQ_EN, 32'h0, RESP_OKAY);
    ev(6'b000100);
    rd(ADDR_FLAGS, 32'h0100_0000, RESP_OKAY);
    cmp("irq", 1'b0, irq);
    wr(ADDR_CMD, 32'h0000_0004, RESP_OKAY);
    ev(6'b010000);
    cmp("err_msg", 2'b00, msg_seen);
    wr(ADDR_DEVCTL, 32'h2, RESP_OKAY);
    ev(6'b010000);
    cmp("err_msg", 2'b01, msg_seen);
    wr(ADDR_DEVCTL, 32'h0, RESP_OKAY);
    wr(ADDR_CMD, 32'h0000_0104, RESP_OKAY);
    ev(6'b100000);
    cmp("err_msg", 2'b10, msg_seen);
    ev(6'b000001);
    cmp("nonfatal", 2, n_nonfatal);
    @(posedge aclk);
    err_fatal <= 1;
    ev(6'b000001);
    cmp("fatal", 2, n_fatal);
    wr(ADDR_CMD, 32'h0000_0004, RESP_OKAY);
    ev(6'b000001);
    cmp("err_msg", 2'b00, msg_seen);
    ev(6'b000010);
    cmp("promote", 1'b0, prom_seen);
    wr(ADDR_CMD, 32'h0000_0014, RESP_OKAY);
    ev(6'b000010);
    cmp("promote", 1'b1, prom_seen);
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    cmp("ctrl", 4'h0, ctrl);
    rd(ADDR_FLAGS, 32'h0, RESP_OKAY);
    rd(ADDR_CMD, CMD_RESET, RESP_OKAY);
    tally_and_finish();
  end
endmodule : bcc_top_bench
